/* File: src/digital_input_signal_router.sv */
`timescale 1ns/10ps
module digital_input_signal_router #(
   parameter int NUM_INPUTS = dinr_pkg::NUM_INPUTS,
   parameter int NUM_PFI = dinr_pkg::NUM_PFI,
   parameter int NUM_DIR_MOD = dinr_pkg::NUM_DIR_MOD,
   parameter int NUM_DIR = dinr_pkg::NUM_DIR
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESETN,
   // Raw input pins and internal PWM sources
   input wire logic [NUM_INPUTS-1:0] INPUT_PIN,
   input wire logic [dinr_pkg::NUM_PWM-1:0] AUX_PWM,
   // Per input conditioning
   input wire logic [NUM_INPUTS-1:0] INPUT_INVERT,
   input wire logic [NUM_INPUTS*dinr_pkg::FILT_W-1:0] INPUT_FILTER_US,
   // Source selections
   input wire logic [dinr_pkg::SEL_W-1:0] CRANK_SOURCE_SELECT,
   input wire logic [dinr_pkg::SEL_W-1:0] INDEX_PULSE_SOURCE_SELECT,
   input wire logic [dinr_pkg::SEL_W-1:0] CAM_A_SOURCE_SELECT,
   input wire logic [dinr_pkg::SEL_W-1:0] CAM_B_SOURCE_SELECT,
   input wire logic [NUM_PFI*dinr_pkg::SEL_W-1:0] PORT_INJECTOR_SOURCE_SELECT,
   input wire logic [NUM_DIR*dinr_pkg::SEL_W-1:0] DIRECT_INJECTOR_CHANNEL_SOURCE_SELECT,
   // Tracker cam input configuration
   input wire logic INDEX_MASK_ENABLE,
   input wire logic INDEX_MASK_CAM_B,
   input wire logic USE_INDEX_PULSE,
   input wire logic PHASE_CAM_B,
   // Driver module presence and modes
   input wire logic PORT_INJECTOR_PRESENT,
   input wire logic [1:0] PORT_INJECTOR_MODE,
   input wire logic [NUM_DIR_MOD-1:0] DIRECT_MODULE_PRESENT,
   input wire logic [NUM_DIR_MOD*2-1:0] DIRECT_MODULE_MODE,
   // Tracker outputs
   output logic TRACKER_CRANK,
   output logic TRACKER_CAM,
   output logic CAM_A,
   output logic CAM_B,
   output logic CAM_A_RISE,
   output logic CAM_B_RISE,
   // Injector channel commands and their enables
   output logic [NUM_PFI-1:0] PORT_INJECTOR_CMD,
   output logic [NUM_PFI-1:0] PORT_INJECTOR_CMD_EN,
   output logic [NUM_DIR-1:0] DIRECT_INJECTOR_CMD,
   output logic [NUM_DIR-1:0] DIRECT_INJECTOR_CMD_EN,
   // Input status
   output logic [NUM_INPUTS-1:0] INPUT_LEVEL,
   output logic [NUM_INPUTS*dinr_pkg::MEAS_W-1:0] INPUT_PERIOD_CYC,
   output logic [NUM_INPUTS*dinr_pkg::MEAS_W-1:0] INPUT_HIGH_CYC
);
   // ****************************************
   // Microsecond tick divider
   // ****************************************
   localparam logic [7:0] US_LAST = 8'(dinr_pkg::CYC_PER_US - 1);
   logic [7:0] us_cnt;
   wire logic us_tick = us_cnt == US_LAST;
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         us_cnt <= 8'h00;
      end else begin
         us_cnt <= us_tick ? 8'h00 : us_cnt + 8'h01;
      end
   end

   // ****************************************
   // Conditioning and measurement per input
   // ****************************************
   logic [NUM_INPUTS-1:0] level;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
         input_conditioner #(
            .FILT_W(dinr_pkg::FILT_W),
            .MEAS_W(dinr_pkg::MEAS_W)
         ) u_cond (
            .clk(CORE_CLK),
            .resetn(RESETN),
            .us_tick(us_tick),
            .raw_pin(INPUT_PIN[gi]),
            .invert(INPUT_INVERT[gi]),
            .filter_us(INPUT_FILTER_US[gi*dinr_pkg::FILT_W +: dinr_pkg::FILT_W]),
            .level(level[gi]),
            .period_cyc(INPUT_PERIOD_CYC[gi*dinr_pkg::MEAS_W +: dinr_pkg::MEAS_W]),
            .high_cyc(INPUT_HIGH_CYC[gi*dinr_pkg::MEAS_W +: dinr_pkg::MEAS_W])
         );
      end
   endgenerate
   assign INPUT_LEVEL = level;

   // ****************************************
   // Source selection
   // ****************************************
   logic [dinr_pkg::NUM_PWM-1:0] pwm_sync1;
   logic [dinr_pkg::NUM_PWM-1:0] pwm;
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         pwm_sync1 <= '0;
         pwm <= '0;
      end else begin
         pwm_sync1 <= AUX_PWM;
         pwm <= pwm_sync1;
      end
   end

   // Code 0 unassigned, then inputs, then PWM generators
   wire logic [15:0] sources = {pwm, level};

   function automatic logic pick(input logic [15:0] src, input logic [4:0] sel);
      logic r;
      r = 1'b0;
      if (sel >= dinr_pkg::SEL_INPUT0 && sel < dinr_pkg::SEL_PWM0 + 5'h04) begin
         r = src[4'(sel - dinr_pkg::SEL_INPUT0)];
      end
      return r;
   endfunction : pick

   function automatic logic mode_ok(input logic [1:0] mode);
      return mode == dinr_pkg::MODE_DIRECT || mode == dinr_pkg::MODE_TMP;
   endfunction : mode_ok

   // Every destination reads the same shared source vector
   wire logic crank_n = pick(sources, CRANK_SOURCE_SELECT);
   wire logic index_n = pick(sources, INDEX_PULSE_SOURCE_SELECT);
   wire logic cam_a_n = pick(sources, CAM_A_SOURCE_SELECT);
   wire logic cam_b_n = pick(sources, CAM_B_SOURCE_SELECT);
   wire logic mask_cam = INDEX_MASK_CAM_B ? cam_b_n : cam_a_n;
   wire logic gated_index = index_n & (mask_cam | !INDEX_MASK_ENABLE);
   wire logic phase_cam = PHASE_CAM_B ? cam_b_n : cam_a_n;
   wire logic tracker_cam_n = USE_INDEX_PULSE ? gated_index : phase_cam;

   logic [NUM_PFI-1:0] pfi_n;
   logic [NUM_PFI-1:0] pfi_en_n;
   logic [NUM_DIR-1:0] dir_n;
   logic [NUM_DIR-1:0] dir_en_n;
   always_comb begin
      for (int i = 0; i < NUM_PFI; i++) begin
         pfi_en_n[i] = PORT_INJECTOR_PRESENT && mode_ok(PORT_INJECTOR_MODE);
         pfi_n[i] = pfi_en_n[i] &&
            pick(sources, PORT_INJECTOR_SOURCE_SELECT[i*dinr_pkg::SEL_W +: dinr_pkg::SEL_W]);
      end
      for (int j = 0; j < NUM_DIR; j++) begin
         dir_en_n[j] = DIRECT_MODULE_PRESENT[j / dinr_pkg::DIR_PER_MOD] &&
            mode_ok(DIRECT_MODULE_MODE[(j / dinr_pkg::DIR_PER_MOD)*2 +: 2]);
         dir_n[j] = dir_en_n[j] && pick(sources,
            DIRECT_INJECTOR_CHANNEL_SOURCE_SELECT[j*dinr_pkg::SEL_W +: dinr_pkg::SEL_W]);
      end
   end

   // ****************************************
   // Registered outputs
   // ****************************************
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         TRACKER_CRANK <= 1'b0;
         TRACKER_CAM <= 1'b0;
         CAM_A <= 1'b0;
         CAM_B <= 1'b0;
         CAM_A_RISE <= 1'b0;
         CAM_B_RISE <= 1'b0;
         PORT_INJECTOR_CMD <= '0;
         PORT_INJECTOR_CMD_EN <= '0;
         DIRECT_INJECTOR_CMD <= '0;
         DIRECT_INJECTOR_CMD_EN <= '0;
      end else begin
         TRACKER_CRANK <= crank_n;
         TRACKER_CAM <= tracker_cam_n;
         CAM_A <= cam_a_n;
         CAM_B <= cam_b_n;
         CAM_A_RISE <= cam_a_n && !CAM_A;
         CAM_B_RISE <= cam_b_n && !CAM_B;
         PORT_INJECTOR_CMD <= pfi_n;
         PORT_INJECTOR_CMD_EN <= pfi_en_n;
         DIRECT_INJECTOR_CMD <= dir_n;
         DIRECT_INJECTOR_CMD_EN <= dir_en_n;
      end
   end
endmodule : digital_input_signal_router

/* File: src/dinr_pkg.sv */
package dinr_pkg;
   // ****************************************
   // Sizes
   // ****************************************
   localparam int NUM_INPUTS = 12;
   localparam int NUM_PWM = 4;
   localparam int NUM_PFI = 4;
   localparam int NUM_DIR_MOD = 4;
   localparam int DIR_PER_MOD = 3;
   localparam int NUM_DIR = 12;
   localparam int SEL_W = 5;
   localparam int FILT_W = 16;
   localparam int MEAS_W = 32;
   // ****************************************
   // Source select codes
   // ****************************************
   localparam logic [4:0] SEL_NONE = 5'h00;
   localparam logic [4:0] SEL_INPUT0 = 5'h01;
   localparam logic [4:0] SEL_PWM0 = 5'h0D;
   // ****************************************
   // Cam choice for the index gate
   // ****************************************
   localparam logic [1:0] IDX_DIRECT = 2'h0;
   localparam logic [1:0] IDX_MASK_A = 2'h1;
   localparam logic [1:0] IDX_MASK_B = 2'h2;
   // ****************************************
   // Driver modes
   // ****************************************
   localparam logic [1:0] MODE_DIRECT = 2'h0;
   localparam logic [1:0] MODE_TMP = 2'h1;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ = 40000000;
   localparam int US_NS = 1000;
   localparam int CLK_NS = 25;
   localparam int CYC_PER_US = (US_NS + CLK_NS - 1) / CLK_NS;
   // Reset values
   localparam logic [MEAS_W-1:0] MEAS_RESET = 32'h00000000;
endpackage : dinr_pkg

/* File: src/input_conditioner.sv */
`timescale 1ns/10ps
module input_conditioner #(
   parameter int FILT_W = 16,
   parameter int MEAS_W = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic us_tick,
   // Raw pin and settings
   input wire logic raw_pin,
   input wire logic invert,
   input wire logic [FILT_W-1:0] filter_us,
   // Conditioned level and measurements
   output logic level,
   output logic [MEAS_W-1:0] period_cyc,
   output logic [MEAS_W-1:0] high_cyc
);
   logic sync1;
   logic sync2;
   logic [FILT_W-1:0] hold_us;
   logic [MEAS_W-1:0] period_cnt;
   logic [MEAS_W-1:0] high_cnt;
   logic level_d;
   wire logic cand = sync2 ^ invert;
   wire logic differs = cand != level;
   wire logic filt_off = filter_us == '0;
   // Count whole ticks after the first partial one, so the hold is never short
   wire logic held = differs && us_tick && (hold_us >= filter_us);
   wire logic accept = differs && (filt_off || held);
   wire logic rise = level && !level_d;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
      end else begin
         sync1 <= raw_pin;
         sync2 <= sync1;
      end
   end
   // ****************************************
   // Invert, then filter by hold time
   // ****************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         level <= 1'b0;
         hold_us <= '0;
      end else if (!differs || accept) begin
         hold_us <= '0;
         level <= cand;
      end else if (us_tick) begin
         hold_us <= hold_us + 1'b1;
      end
   end
   // ****************************************
   // Period and high time between rising edges
   // ****************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         level_d <= 1'b0;
         period_cnt <= '0;
         high_cnt <= '0;
         period_cyc <= '0;
         high_cyc <= '0;
      end else begin
         level_d <= level;
         if (rise) begin
            period_cyc <= period_cnt;
            high_cyc <= high_cnt;
            period_cnt <= MEAS_W'(1);
            high_cnt <= MEAS_W'(1);
         end else begin
            if (~&period_cnt) period_cnt <= period_cnt + 1'b1;
            if (level && ~&high_cnt) high_cnt <= high_cnt + 1'b1;
         end
      end
   end
endmodule : input_conditioner

/* File: test/dinr_sva.sv */
`timescale 1ns/10ps
// ****************************************
// Router checker
// ****************************************
module dinr_sva (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESETN,
   // Watched inputs
   input wire logic [11:0] INPUT_PIN,
   input wire logic [11:0] INPUT_INVERT,
   input wire logic [191:0] INPUT_FILTER_US,
   input wire logic [4:0] CRANK_SOURCE_SELECT,
   input wire logic [4:0] CAM_A_SOURCE_SELECT,
   input wire logic [4:0] CAM_B_SOURCE_SELECT,
   input wire logic INDEX_MASK_ENABLE,
   input wire logic INDEX_MASK_CAM_B,
   input wire logic USE_INDEX_PULSE,
   input wire logic PHASE_CAM_B,
   input wire logic PORT_INJECTOR_PRESENT,
   input wire logic [1:0] PORT_INJECTOR_MODE,
   // Watched outputs
   input wire logic TRACKER_CRANK,
   input wire logic TRACKER_CAM,
   input wire logic CAM_A,
   input wire logic CAM_B,
   input wire logic CAM_A_RISE,
   input wire logic [3:0] PORT_INJECTOR_CMD,
   input wire logic [3:0] PORT_INJECTOR_CMD_EN,
   input wire logic [11:0] INPUT_LEVEL
);
   logic [1:0] up;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);
   // Cycles since reset, so the pin pipeline is full
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         up <= 2'h0;
      end else if (up != 2'h3) begin
         up <= up + 2'h1;
      end
   end
   a_crank_follows: assert property (
      CRANK_SOURCE_SELECT inside {[5'h01:5'h0C]} && $stable(CRANK_SOURCE_SELECT)
      |-> TRACKER_CRANK == $past(INPUT_LEVEL[CRANK_SOURCE_SELECT - 5'h01]))
      else $error("crank output does not follow its source");
   a_level_tracks_pin: assert property (
      up == 2'h3 && INPUT_FILTER_US[15:0] == 16'h0000 && $stable(INPUT_INVERT[0])
      |-> INPUT_LEVEL[0] == ($past(INPUT_PIN[0], 3) ^ INPUT_INVERT[0]))
      else $error("input level does not track the pin");
   a_mask_blocks_index: assert property (
      $past(USE_INDEX_PULSE && INDEX_MASK_ENABLE && !INDEX_MASK_CAM_B) && TRACKER_CAM |-> CAM_A)
      else $error("index passed while cam A low");
   a_phase_cam_b: assert property (
      $past(!USE_INDEX_PULSE && PHASE_CAM_B) |-> TRACKER_CAM == CAM_B)
      else $error("tracker cam differs from cam B");
   a_shared_source_copy: assert property (
      CAM_A_SOURCE_SELECT == CAM_B_SOURCE_SELECT && $stable(CAM_A_SOURCE_SELECT)
      && $stable(CAM_B_SOURCE_SELECT) |-> CAM_A == CAM_B)
      else $error("shared source gives different copies");
   a_rise_one_cycle: assert property (CAM_A_RISE |=> !CAM_A_RISE)
      else $error("cam rise pulse too long");
   a_port_mode_gate: assert property (
      PORT_INJECTOR_CMD_EN != 4'h0
      |-> $past(PORT_INJECTOR_PRESENT) && $past(PORT_INJECTOR_MODE) <= 2'h1)
      else $error("port channel enabled without module or mode");
   a_port_off_zero: assert property (
      (PORT_INJECTOR_CMD & ~PORT_INJECTOR_CMD_EN) == 4'h0)
      else $error("disabled port channel commands high");
endmodule : dinr_sva
bind digital_input_signal_router dinr_sva u_dinr_sva (.*);

/* File: test/sensor_model.sv */
`timescale 1ns/10ps
// ****************************************
// Wheel sensor
// ****************************************
module sensor_model #(
   parameter int HALF = 10
) (
   // Clock, enable and sensor line
   input wire logic clk,
   input wire logic en,
   output logic pin
);
   int cnt = 0;
   initial pin = 1'b0;
   always @(negedge clk) begin
      if (!en) begin
         cnt <= 0;
         pin <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         pin <= ~pin;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : sensor_model

/* File: test/tb_digital_input_signal_router.sv */
`timescale 1ns/10ps
// ****************************************
// Router bench
// ****************************************
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
   $display("BAD %0t %h %h", $time, a, b); end end
module tb_digital_input_signal_router;
   typedef struct packed {logic [4:0] s; logic [11:0] p; logic [11:0] i; logic [3:0] w;
      logic e;} row_s;
   row_s rows [8] = '{'{5'h00, 12'hFFF, 12'h000, 4'hF, 1'b0}, '{5'h01, 12'h001, 12'h000, 4'h0, 1'b1},
      '{5'h0C, 12'h800, 12'h000, 4'h0, 1'b1}, '{5'h0C, 12'h800, 12'h800, 4'h0, 1'b0},
      '{5'h05, 12'h000, 12'h010, 4'h0, 1'b1}, '{5'h0D, 12'h000, 12'h000, 4'h1, 1'b1},
      '{5'h10, 12'hFFF, 12'h000, 4'h7, 1'b0}, '{5'h11, 12'hFFF, 12'h000, 4'hF, 1'b0}};
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [11:0] pins = 12'h000;
   logic [11:0] inv = 12'h000;
   logic [3:0] pwm = 4'h0;
   logic [191:0] filt = 192'h0;
   logic [4:0] sel = 5'h00;
   logic [4:0] isel = 5'h00;
   logic [4:0] asel = 5'h00;
   logic [4:0] bsel = 5'h00;
   logic [3:0] cfg = 4'h0;
   logic pp = 1'b1;
   logic [1:0] pm = 2'h0;
   logic [3:0] dp = 4'hF;
   logic [7:0] dm = 8'h00;
   logic wen = 1'b0;
   wire logic wheel, tcrank, tcam, ca, cb, car;
   wire logic [3:0] pcmd, pen;
   wire logic [11:0] dcmd, den, lvl;
   wire logic [383:0] per, hi;
   int fails = 0;
   int compares = 0;
   int n;
   always #12.5 clk = ~clk;
   sensor_model #(.HALF(10)) u_sensor_model (.clk(clk), .en(wen), .pin(wheel));
   digital_input_signal_router u_digital_input_signal_router (.CORE_CLK(clk), .RESETN(rstn),
      .INPUT_PIN(pins | {11'h000, wheel}), .AUX_PWM(pwm), .INPUT_INVERT(inv),
      .INPUT_FILTER_US(filt), .CRANK_SOURCE_SELECT(sel), .INDEX_PULSE_SOURCE_SELECT(isel),
      .CAM_A_SOURCE_SELECT(asel), .CAM_B_SOURCE_SELECT(bsel),
      .PORT_INJECTOR_SOURCE_SELECT({4{sel}}), .DIRECT_INJECTOR_CHANNEL_SOURCE_SELECT({12{sel}}),
      .INDEX_MASK_ENABLE(cfg[2]), .INDEX_MASK_CAM_B(cfg[1]), .USE_INDEX_PULSE(cfg[3]),
      .PHASE_CAM_B(cfg[0]), .PORT_INJECTOR_PRESENT(pp), .PORT_INJECTOR_MODE(pm),
      .DIRECT_MODULE_PRESENT(dp), .DIRECT_MODULE_MODE(dm), .TRACKER_CRANK(tcrank),
      .TRACKER_CAM(tcam), .CAM_A(ca), .CAM_B(cb), .CAM_A_RISE(car), .CAM_B_RISE(),
      .PORT_INJECTOR_CMD(pcmd), .PORT_INJECTOR_CMD_EN(pen), .DIRECT_INJECTOR_CMD(dcmd),
      .DIRECT_INJECTOR_CMD_EN(den), .INPUT_LEVEL(lvl), .INPUT_PERIOD_CYC(per),
      .INPUT_HIGH_CYC(hi));
   task cyc(input int k);
      repeat (k) @(negedge clk);
   endtask : cyc
   task tc(input logic [3:0] c, input logic [2:0] p, input logic e);
      cfg = c;
      pins = {8'h00, p, 1'b0};
      cyc(6);
      `CHK(tcam, e)
   endtask : tc
   task wrap_up;
      $display("%0d compares %0d fails", compares, fails);
      if (fails == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   initial begin
      #(5000 * 25);
      fails++;
      wrap_up();
   end
   initial begin
      cyc(8);
      rstn = 1'b1;
      for (n = 0; n < 8; n++) begin
         {sel, asel, bsel} = {3{rows[n].s}};
         {pins, inv, pwm} = {rows[n].p, rows[n].i, rows[n].w};
         cyc(6);
         `CHK(tcrank, rows[n].e)
         `CHK({ca, cb}, {2{rows[n].e}})
         `CHK({pcmd, dcmd}, {16{rows[n].e}})
         `CHK(lvl, rows[n].p ^ rows[n].i)
      end
      $display("table done");
      {sel, pins, pp, dp} = {5'h01, 12'h001, 1'b0, 4'h5};
      cyc(6);
      `CHK({pen, pcmd}, 8'h00)
      `CHK({den, dcmd}, {2{12'h1C7}})
      {pp, pm, dp, dm} = {1'b1, 2'h1, 4'hF, 8'h20};
      cyc(3);
      `CHK({pen, pcmd}, 8'hFF)
      `CHK(den, 12'hE3F)
      pm = 2'h3;
      cyc(3);
      `CHK(pen, 4'h0)
      $display("gating done");
      {isel, asel, bsel} = {5'h02, 5'h03, 5'h04};
      tc(4'hC, 3'b001, 1'b0);
      tc(4'hC, 3'b011, 1'b1);
      tc(4'h8, 3'b001, 1'b1);
      tc(4'hE, 3'b011, 1'b0);
      tc(4'hE, 3'b101, 1'b1);
      tc(4'h1, 3'b100, 1'b1);
      tc(4'h0, 3'b100, 1'b0);
      $display("index done");
      {pins, sel, asel, wen, n} = {12'h000, 5'h01, 5'h01, 1'b1, 32'h0};
      cyc(40);
      repeat (400) begin
         @(negedge clk);
         if (car === 1'b1) n++;
      end
      `CHK(n, 20)
      `CHK({per[31:0], hi[31:0]}, {32'h00000014, 32'h0000000A})
      wen = 1'b0;
      $display("wheel done");
      filt[79:64] = 16'h0002;
      cyc(20);
      pins[4] = 1'b1;
      cyc(30);
      pins[4] = 1'b0;
      cyc(120);
      `CHK(lvl[4], 1'b0)
      pins[4] = 1'b1;
      cyc(60);
      `CHK(lvl[4], 1'b0)
      cyc(100);
      `CHK(lvl[4], 1'b1)
      $display("filter done");
      pins = 12'hFFF;
      cyc(6);
      rstn = 1'b0;
      cyc(2);
      `CHK({tcrank, lvl}, 13'h0000)
      rstn = 1'b1;
      $display("reset done");
      wrap_up();
   end
endmodule : tb_digital_input_signal_router
